// file: inc/rsm_regs.svh
// register offsets, field positions, reset values and sample mask constants of the sample mask block
`ifndef RSM_REGS_SVH
`define RSM_REGS_SVH

`define RSM_OFF_OP 12'h000
`define RSM_OFF_OP_MASK 12'h004
`define RSM_OFF_SMASK 12'h008
`define RSM_OFF_MSAA 12'h00c
`define RSM_OFF_SF_NORM 12'h010
`define RSM_OFF_WM_NORM 12'h014
`define RSM_OFF_STATUS 12'h018
`define RSM_OFF_SF_OUT 12'h01c
`define RSM_OFF_WM_OUT 12'h020

`define RSM_WMASK_OP 32'h0000_173f
`define RSM_WMASK_16 32'h0000_ffff
`define RSM_WMASK_MSAA 32'h0000_0007
`define RSM_WMASK_SF 32'h0fff_f7ff
`define RSM_WMASK_WM 32'h0003_ffff

`define RSM_RST_OP 32'h0000_0000
`define RSM_RST_OP_MASK 32'h0000_ffff
`define RSM_RST_SMASK 32'h0000_ffff
`define RSM_RST_MSAA 32'h0000_0000
`define RSM_RST_SF 32'h0000_0000
`define RSM_RST_WM 32'h0000_0000

`define RSM_OP_DCLR 0
`define RSM_OP_DRES 1
`define RSM_OP_HZRES 2
`define RSM_OP_SRES 3
`define RSM_OP_SCLR 4
`define RSM_OP_PDRES 5
`define RSM_OP_CNT 8
`define RSM_OP_SCIS 12

`define RSM_SF_STAT 0
`define RSM_SF_VXF 1
`define RSM_SF_RTIR 2
`define RSM_SF_HASHD 3
`define RSM_SF_FILL 4
`define RSM_SF_CULL 6
`define RSM_SF_WIND 8
`define RSM_SF_MSR 9
`define RSM_SF_VP 12
`define RSM_SF_RTA 16
`define RSM_SF_SCIS 27

`define RSM_WM_DTE 0
`define RSM_WM_DFN 1
`define RSM_WM_DWE 4
`define RSM_WM_STE 5
`define RSM_WM_SWE 6
`define RSM_WM_SFN 7
`define RSM_WM_SPOP 10
`define RSM_WM_TDE 13
`define RSM_WM_KILL 14
`define RSM_WM_PSCD 15
`define RSM_WM_STAT 17

`define RSM_ST_CNT 4
`define RSM_ST_MASK 16

`define RSM_MASK_EN_1 16'h0001
`define RSM_MASK_EN_2 16'h0003
`define RSM_MASK_EN_4 16'h000f
`define RSM_MASK_EN_8 16'h00ff
`define RSM_MASK_EN_16 16'hffff

`endif

// file: inc/rsm_pkg.sv
// encodings shared by the sample mask and override logic
package rsm_pkg;
	typedef enum logic [2:0] {
		one_sample_count = 3'h0,
		two_sample_count = 3'h1,
		four_sample_count = 3'h2,
		eight_sample_count = 3'h3,
		sixteen_sample_count = 3'h4
	} rsm_samples_t;
	typedef enum logic [1:0] {
		ms_off_pixel = 2'h0,
		ms_off_pattern = 2'h1,
		ms_on_pixel = 2'h2,
		ms_on_pattern = 2'h3
	} rsm_ms_mode_t;
	typedef enum logic [1:0] {
		cull_both = 2'h0,
		no_face_cull = 2'h1,
		front_face_cull = 2'h2,
		back_face_cull = 2'h3
	} rsm_cull_t;
	typedef enum logic [1:0] {
		fill_solid = 2'h0,
		fill_wireframe = 2'h1,
		fill_point = 2'h2
	} rsm_fill_t;
	typedef enum logic [2:0] {
		cmp_always = 3'h0,
		cmp_never = 3'h1,
		cmp_less = 3'h2,
		cmp_equal = 3'h3,
		cmp_lequal = 3'h4,
		cmp_greater = 3'h5,
		cmp_notequal = 3'h6,
		cmp_gequal = 3'h7
	} rsm_cmp_t;
	typedef enum logic [2:0] {
		sop_keep = 3'h0,
		sop_zero = 3'h1,
		sop_replace = 3'h2,
		sop_incr = 3'h3
	} rsm_sop_t;
	typedef enum logic [1:0] {
		shader_depth_off = 2'h0,
		shader_depth_on = 2'h1,
		shader_depth_ge = 2'h2,
		shader_depth_le = 2'h3
	} rsm_pscd_t;
	localparam logic clockwise_front_winding = 1'h0;
endpackage

// file: design/rsm_mask_gen.sv
// sample mask enable from the sample count and effective rasterisation mask
`timescale 1ns/1ps
`include "rsm_regs.svh"
module rsm_mask_gen
	import rsm_pkg::*;
(
	input wire rsm_samples_t count,
	input wire logic op_active,
	input wire logic [15:0] op_mask,
	input wire logic [15:0] pkt_mask,
	output logic [15:0] mask_enable,
	output logic [15:0] sample_mask
);
	wire logic [15:0] selected_mask;

	// illegal count codes fall back to a single sample so no phantom samples are lit
	assign mask_enable = (count == two_sample_count) ? `RSM_MASK_EN_2 :
		(count == four_sample_count) ? `RSM_MASK_EN_4 :
		(count == eight_sample_count) ? `RSM_MASK_EN_8 :
		(count == sixteen_sample_count) ? `RSM_MASK_EN_16 :
		`RSM_MASK_EN_1;
	assign selected_mask = op_active ? op_mask : pkt_mask;
	assign sample_mask = mask_enable & selected_mask;
endmodule

// file: design/rsm_sf_override.sv
// setup stage overrides applied while a depth/stencil clear or resolve runs
`timescale 1ns/1ps
module rsm_sf_override
	import rsm_pkg::*;
(
	input wire logic op_active,
	input wire rsm_samples_t op_count,
	input wire logic op_scissor,
	input wire logic nrm_stat,
	input wire logic nrm_vxf,
	input wire logic nrm_rtir,
	input wire logic nrm_hash_dis,
	input wire rsm_fill_t nrm_fill,
	input wire rsm_cull_t nrm_cull,
	input wire logic nrm_wind,
	input wire rsm_ms_mode_t nrm_ms_mode,
	input wire logic [10:0] nrm_rta_idx,
	input wire logic [3:0] nrm_vp_idx,
	input wire logic nrm_scissor,
	output logic ovr_stat,
	output logic ovr_vxf,
	output logic ovr_rtir,
	output logic ovr_hash_dis,
	output rsm_fill_t ovr_fill,
	output rsm_cull_t ovr_cull,
	output logic ovr_wind,
	output rsm_ms_mode_t ovr_ms_mode,
	output logic [10:0] ovr_rta_idx,
	output logic [3:0] ovr_vp_idx,
	output logic ovr_scissor
);
	wire rsm_ms_mode_t op_ms_mode;

	// illegal count codes count as one sample, in step with the mask enable
	assign op_ms_mode = (op_count inside {two_sample_count, four_sample_count, eight_sample_count,
		sixteen_sample_count}) ? ms_on_pattern : ms_on_pixel;
	assign ovr_ms_mode = op_active ? op_ms_mode : nrm_ms_mode;
	assign ovr_cull = op_active ? back_face_cull : nrm_cull;
	assign ovr_wind = op_active ? clockwise_front_winding : nrm_wind;
	assign ovr_rta_idx = op_active ? 11'h000 : nrm_rta_idx;
	assign ovr_vp_idx = op_active ? 4'h0 : nrm_vp_idx;
	assign ovr_stat = op_active ? 1'h0 : nrm_stat;
	assign ovr_vxf = op_active ? 1'h0 : nrm_vxf;
	assign ovr_rtir = op_active ? 1'h0 : nrm_rtir;
	assign ovr_hash_dis = op_active ? 1'h0 : nrm_hash_dis;
	assign ovr_fill = op_active ? fill_solid : nrm_fill;
	// the op packet brings its own scissor choice
	assign ovr_scissor = op_active ? op_scissor : nrm_scissor;
endmodule

// file: design/rsm_top.sv
// apb register file, clear/resolve decode, windower overrides and registered derived state
`timescale 1ns/1ps
`include "rsm_regs.svh"
module rsm_top
	import rsm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic op_active_out,
	output logic [15:0] sample_mask_out,
	output logic sf_stat,
	output logic sf_vxf,
	output logic sf_rtir,
	output logic sf_hash_dis,
	output rsm_fill_t sf_fill,
	output rsm_cull_t sf_cull,
	output logic sf_wind,
	output rsm_ms_mode_t sf_ms_mode,
	output logic [10:0] sf_rta_idx,
	output logic [3:0] sf_vp_idx,
	output logic sf_scissor,
	output logic wm_depth_test,
	output rsm_cmp_t wm_depth_fn,
	output logic wm_depth_write,
	output logic wm_stencil_test,
	output logic wm_stencil_write,
	output rsm_cmp_t wm_stencil_fn,
	output rsm_sop_t wm_stencil_op,
	output logic wm_dispatch,
	output logic wm_kill,
	output rsm_pscd_t wm_pscd,
	output logic wm_stat
);
	logic [31:0] op_reg;
	logic [31:0] op_mask_reg;
	logic [31:0] smask_reg;
	logic [31:0] msaa_reg;
	logic [31:0] sf_norm_reg;
	logic [31:0] wm_norm_reg;

	// apb decode; one wait state so read data and answer both come from flops
	wire logic apb_access = psel & penable & ~pready;
	wire logic apb_done = psel & penable & pready;
	wire logic wr_en = apb_done & pwrite;
	wire logic hit_op = paddr == `RSM_OFF_OP;
	wire logic hit_op_mask = paddr == `RSM_OFF_OP_MASK;
	wire logic hit_smask = paddr == `RSM_OFF_SMASK;
	wire logic hit_msaa = paddr == `RSM_OFF_MSAA;
	wire logic hit_sf = paddr == `RSM_OFF_SF_NORM;
	wire logic hit_wm = paddr == `RSM_OFF_WM_NORM;
	wire logic hit_status = paddr == `RSM_OFF_STATUS;
	wire logic hit_sf_out = paddr == `RSM_OFF_SF_OUT;
	wire logic hit_wm_out = paddr == `RSM_OFF_WM_OUT;
	wire logic hit_rw = hit_op | hit_op_mask | hit_smask | hit_msaa | hit_sf | hit_wm;
	wire logic hit_ro = hit_status | hit_sf_out | hit_wm_out;
	// writes to read-only words are refused like unmapped ones
	wire logic bad_access = pwrite ? ~hit_rw : ~(hit_rw | hit_ro);
	wire logic [31:0] strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	function automatic logic [31:0] upd(input logic [31:0] old, input logic hit, input logic [31:0] allow);
		logic [31:0] m;
		m = strb_mask & allow;
		upd = (wr_en & hit) ? ((old & ~m) | (pwdata & m)) : old;
	endfunction

	wire logic [31:0] op_next = upd(op_reg, hit_op, `RSM_WMASK_OP);
	wire logic [31:0] op_mask_next = upd(op_mask_reg, hit_op_mask, `RSM_WMASK_16);
	wire logic [31:0] smask_next = upd(smask_reg, hit_smask, `RSM_WMASK_16);
	wire logic [31:0] msaa_next = upd(msaa_reg, hit_msaa, `RSM_WMASK_MSAA);
	wire logic [31:0] sf_norm_next = upd(sf_norm_reg, hit_sf, `RSM_WMASK_SF);
	wire logic [31:0] wm_norm_next = upd(wm_norm_reg, hit_wm, `RSM_WMASK_WM);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			op_reg <= `RSM_RST_OP;
			op_mask_reg <= `RSM_RST_OP_MASK;
			smask_reg <= `RSM_RST_SMASK;
			msaa_reg <= `RSM_RST_MSAA;
			sf_norm_reg <= `RSM_RST_SF;
			wm_norm_reg <= `RSM_RST_WM;
		end
		else
		begin
			op_reg <= op_next;
			op_mask_reg <= op_mask_next;
			smask_reg <= smask_next;
			msaa_reg <= msaa_next;
			sf_norm_reg <= sf_norm_next;
			wm_norm_reg <= wm_norm_next;
		end
	end

	// request bits of the clear/resolve op packet
	wire logic req_dclr = op_reg[`RSM_OP_DCLR];
	wire logic req_sclr = op_reg[`RSM_OP_SCLR];
	wire logic req_dres = op_reg[`RSM_OP_DRES] | op_reg[`RSM_OP_PDRES];
	wire logic op_active_w = |op_reg[`RSM_OP_PDRES:`RSM_OP_DCLR];
	wire rsm_samples_t op_cnt = rsm_samples_t'(op_reg[`RSM_OP_CNT +: 3]);
	// the op's own sample count replaces the programmed one while it runs
	wire rsm_samples_t eff_cnt = op_active_w ? op_cnt : rsm_samples_t'(msaa_reg[2:0]);
	wire logic [15:0] mask_w;

	rsm_mask_gen u_mask (
		.count(eff_cnt),
		.op_active(op_active_w),
		.op_mask(op_mask_reg[15:0]),
		.pkt_mask(smask_reg[15:0]),
		.mask_enable(),
		.sample_mask(mask_w)
	);

	wire logic sf_stat_w;
	wire logic sf_vxf_w;
	wire logic sf_rtir_w;
	wire logic sf_hash_w;
	wire rsm_fill_t sf_fill_w;
	wire rsm_cull_t sf_cull_w;
	wire logic sf_wind_w;
	wire rsm_ms_mode_t sf_ms_w;
	wire logic [10:0] sf_rta_w;
	wire logic [3:0] sf_vp_w;
	wire logic sf_scis_w;

	rsm_sf_override u_sf (
		.op_active(op_active_w),
		.op_count(op_cnt),
		.op_scissor(op_reg[`RSM_OP_SCIS]),
		.nrm_stat(sf_norm_reg[`RSM_SF_STAT]),
		.nrm_vxf(sf_norm_reg[`RSM_SF_VXF]),
		.nrm_rtir(sf_norm_reg[`RSM_SF_RTIR]),
		.nrm_hash_dis(sf_norm_reg[`RSM_SF_HASHD]),
		.nrm_fill(rsm_fill_t'(sf_norm_reg[`RSM_SF_FILL +: 2])),
		.nrm_cull(rsm_cull_t'(sf_norm_reg[`RSM_SF_CULL +: 2])),
		.nrm_wind(sf_norm_reg[`RSM_SF_WIND]),
		.nrm_ms_mode(rsm_ms_mode_t'(sf_norm_reg[`RSM_SF_MSR +: 2])),
		.nrm_rta_idx(sf_norm_reg[`RSM_SF_RTA +: 11]),
		.nrm_vp_idx(sf_norm_reg[`RSM_SF_VP +: 4]),
		.nrm_scissor(sf_norm_reg[`RSM_SF_SCIS]),
		.ovr_stat(sf_stat_w),
		.ovr_vxf(sf_vxf_w),
		.ovr_rtir(sf_rtir_w),
		.ovr_hash_dis(sf_hash_w),
		.ovr_fill(sf_fill_w),
		.ovr_cull(sf_cull_w),
		.ovr_wind(sf_wind_w),
		.ovr_ms_mode(sf_ms_w),
		.ovr_rta_idx(sf_rta_w),
		.ovr_vp_idx(sf_vp_w),
		.ovr_scissor(sf_scis_w)
	);

	// windower depth/stencil overrides; stencil clear column wins when several requests combine, except depth write stays on with a depth clear
	wire logic dte_w = op_active_w ? (req_dres & ~req_dclr & ~req_sclr) : wm_norm_reg[`RSM_WM_DTE];
	wire rsm_cmp_t dfn_w = op_active_w ? cmp_never : rsm_cmp_t'(wm_norm_reg[`RSM_WM_DFN +: 3]);
	wire logic dwe_w = op_active_w ? (req_sclr ? req_dclr : 1'h1) : wm_norm_reg[`RSM_WM_DWE];
	wire logic ste_w = op_active_w ? req_sclr : wm_norm_reg[`RSM_WM_STE];
	wire logic swe_w = op_active_w ? req_sclr : wm_norm_reg[`RSM_WM_SWE];
	wire logic sclr_on = op_active_w & req_sclr;
	wire rsm_cmp_t sfn_w = sclr_on ? cmp_always : rsm_cmp_t'(wm_norm_reg[`RSM_WM_SFN +: 3]);
	wire rsm_sop_t spop_w = sclr_on ? sop_replace : rsm_sop_t'(wm_norm_reg[`RSM_WM_SPOP +: 3]);
	wire logic tde_w = op_active_w ? 1'h0 : wm_norm_reg[`RSM_WM_TDE];
	wire logic kill_w = op_active_w ? 1'h0 : wm_norm_reg[`RSM_WM_KILL];
	wire rsm_pscd_t pscd_w = op_active_w ? shader_depth_off : rsm_pscd_t'(wm_norm_reg[`RSM_WM_PSCD +: 2]);
	wire logic wstat_w = op_active_w ? 1'h0 : wm_norm_reg[`RSM_WM_STAT];

	// readback of the derived state in the same layout as the normal words
	wire logic [31:0] status_rd = {sample_mask_out, 9'h000, eff_cnt, 3'h0, op_active_out};
	wire logic [31:0] sf_out_rd = {4'h0, sf_scissor, sf_rta_idx, sf_vp_idx, 1'h0, sf_ms_mode, sf_wind,
		sf_cull, sf_fill, sf_hash_dis, sf_rtir, sf_vxf, sf_stat};
	wire logic [31:0] wm_out_rd = {14'h0000, wm_stat, wm_pscd, wm_kill, wm_dispatch, wm_stencil_op, wm_stencil_fn,
		wm_stencil_write, wm_stencil_test, wm_depth_write, wm_depth_fn, wm_depth_test};
	wire logic [31:0] rd_mux = hit_op ? op_reg :
		hit_op_mask ? op_mask_reg :
		hit_smask ? smask_reg :
		hit_msaa ? msaa_reg :
		hit_sf ? sf_norm_reg :
		hit_wm ? wm_norm_reg :
		hit_status ? status_rd :
		hit_sf_out ? sf_out_rd :
		hit_wm_out ? wm_out_rd : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'h0;
			pslverr <= 1'h0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= apb_access;
			pslverr <= apb_access & bad_access;
			prdata <= (apb_access & ~pwrite & ~bad_access) ? rd_mux : 32'h0000_0000;
		end
	end

	// derived state is registered so downstream sees a clean edge; one cycle after the write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			op_active_out <= 1'h0;
			sample_mask_out <= 16'h0000;
			sf_stat <= 1'h0;
			sf_vxf <= 1'h0;
			sf_rtir <= 1'h0;
			sf_hash_dis <= 1'h0;
			sf_fill <= fill_solid;
			sf_cull <= cull_both;
			sf_wind <= 1'h0;
			sf_ms_mode <= ms_off_pixel;
			sf_rta_idx <= 11'h000;
			sf_vp_idx <= 4'h0;
			sf_scissor <= 1'h0;
			wm_depth_test <= 1'h0;
			wm_depth_fn <= cmp_always;
			wm_depth_write <= 1'h0;
			wm_stencil_test <= 1'h0;
			wm_stencil_write <= 1'h0;
			wm_stencil_fn <= cmp_always;
			wm_stencil_op <= sop_keep;
			wm_dispatch <= 1'h0;
			wm_kill <= 1'h0;
			wm_pscd <= shader_depth_off;
			wm_stat <= 1'h0;
		end
		else
		begin
			op_active_out <= op_active_w;
			sample_mask_out <= mask_w;
			sf_stat <= sf_stat_w;
			sf_vxf <= sf_vxf_w;
			sf_rtir <= sf_rtir_w;
			sf_hash_dis <= sf_hash_w;
			sf_fill <= sf_fill_w;
			sf_cull <= sf_cull_w;
			sf_wind <= sf_wind_w;
			sf_ms_mode <= sf_ms_w;
			sf_rta_idx <= sf_rta_w;
			sf_vp_idx <= sf_vp_w;
			sf_scissor <= sf_scis_w;
			wm_depth_test <= dte_w;
			wm_depth_fn <= dfn_w;
			wm_depth_write <= dwe_w;
			wm_stencil_test <= ste_w;
			wm_stencil_write <= swe_w;
			wm_stencil_fn <= sfn_w;
			wm_stencil_op <= spop_w;
			wm_dispatch <= tde_w;
			wm_kill <= kill_w;
			wm_pscd <= pscd_w;
			wm_stat <= wstat_w;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_mask_small: assert property (
		(!op_active_w && msaa_reg[2:0] == 3'h1) |=> sample_mask_out == ($past(smask_reg[15:0]) & 16'h0003))
		else $error("two-sample mask enable wrong");
	a_mask_large: assert property (
		(op_active_w && op_cnt == eight_sample_count) |=> sample_mask_out == ($past(op_mask_reg[15:0]) & 16'h00ff))
		else $error("eight-sample mask enable wrong");
	a_mask_select: assert property (
		(op_active_w && op_cnt == sixteen_sample_count) |=> sample_mask_out == $past(op_mask_reg[15:0]))
		else $error("op mask not selected during op");
	a_op_decode: assert property (
		$rose(op_reg[`RSM_OP_SRES]) |-> ##1 op_active_out)
		else $error("stencil resolve did not raise op active");
	a_raster_mode: assert property (
		(op_active_w && op_cnt == one_sample_count) |=> sf_ms_mode == ms_on_pixel)
		else $error("single-sample op must use pixel mode");
	a_cull_wind: assert property (
		op_active_out |-> (sf_cull == back_face_cull && sf_wind == clockwise_front_winding))
		else $error("cull or winding not forced");
	a_index_zero: assert property (
		op_active_out |-> (sf_rta_idx == 11'h000 && sf_vp_idx == 4'h0))
		else $error("indices not zero during op");
	a_depth_test: assert property (
		(op_active_w && req_dclr) |=> !wm_depth_test && wm_depth_fn == cmp_never)
		else $error("depth test on for depth clear");
	a_depth_write: assert property (
		(op_active_w && req_sclr && !req_dclr) |=> !wm_depth_write)
		else $error("depth write on for plain stencil clear");
	a_stencil_clr: assert property (
		(op_active_w && req_sclr) |=> wm_stencil_test && wm_stencil_fn == cmp_always && wm_stencil_op == sop_replace)
		else $error("stencil clear overrides missing");
	a_stencil_res: assert property (
		(op_active_w && !req_sclr) |=> !wm_stencil_write)
		else $error("stencil write on without stencil clear");
	a_ps_off: assert property (
		op_active_out |-> !wm_dispatch && !wm_kill && wm_pscd == shader_depth_off)
		else $error("pixel shader not quiet during op");
	a_pass_thru: assert property (
		!op_active_w |=> wm_stencil_fn == $past(wm_norm_reg[`RSM_WM_SFN +: 3])
			&& sf_cull == $past(sf_norm_reg[`RSM_SF_CULL +: 2]))
		else $error("normal state not passed through");
	a_sf_forced: assert property (
		op_active_out |-> !sf_stat && !sf_vxf && !sf_rtir && !sf_hash_dis && sf_fill == fill_solid)
		else $error("setup controls not forced");
	a_depth_never: assert property (
		op_active_out |-> wm_depth_fn == cmp_never)
		else $error("depth function not never during op");
	a_resolve_depth: assert property (
		(op_active_w && req_dres && !req_dclr && !req_sclr) |=> wm_depth_test && wm_depth_write)
		else $error("depth resolve lost depth test or write");
	a_apb_answer: assert property (
		(psel && !penable) ##1 (psel && penable) |-> ##1 pready)
		else $error("apb answer late");

	c_stencil_clear: cover property (op_active_out && wm_stencil_test && wm_depth_write);
	c_depth_resolve: cover property (op_active_out && wm_depth_test);
	c_sixteen_mask: cover property (!op_active_w && msaa_reg[2:0] == 3'h4 ##1 sample_mask_out == 16'hffff);
	c_apb_error: cover property (pready && pslverr);
endmodule

// file: verif/rsm_apb_master.sv
// apb master model standing in for the upstream state streamer
`timescale 1ns/1ps
module rsm_apb_master
(
	input wire logic pclk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb
);
	// render-target fast clear and resolve, legacy depth controls and pixel location are never programmed
	// here, so they stay off or at defaults
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
	end
	// right after a rising edge pready still shows the value that edge sampled
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] rd, output logic er, output logic to);
		int n;
		begin
			n = 0;
			@(posedge pclk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
			pstrb <= s;
			@(posedge pclk);
			penable <= 1'b1;
			do
			begin
				@(posedge pclk);
				n++;
			end
			while (pready !== 1'b1 && n < 20);
			rd = prdata;
			er = pslverr;
			to = (pready !== 1'b1);
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
endmodule

// file: verif/test_rsm_top.sv
// self-checking bench for the sample mask and clear/resolve override block
`timescale 1ns/1ps
`include "rsm_regs.svh"
module test_rsm_top
	import rsm_pkg::*;
;
	typedef struct packed {logic [15:0] op; logic [2:0] cnt; logic [15:0] smask; logic alt; logic [15:0] mask;} rsm_row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	wire logic psel, penable, pwrite, pready, pslverr, op_active_out;
	wire logic [11:0] paddr;
	wire logic [31:0] pwdata, prdata;
	wire logic [3:0] pstrb;
	wire logic [15:0] sample_mask_out;
	wire logic sf_stat, sf_vxf, sf_rtir, sf_hash_dis, sf_wind, sf_scissor;
	wire rsm_fill_t sf_fill;
	wire rsm_cull_t sf_cull;
	wire rsm_ms_mode_t sf_ms_mode;
	wire logic [10:0] sf_rta_idx;
	wire logic [3:0] sf_vp_idx;
	wire logic wm_depth_test, wm_depth_write, wm_stencil_test, wm_stencil_write, wm_dispatch, wm_kill, wm_stat;
	wire rsm_cmp_t wm_depth_fn, wm_stencil_fn;
	wire rsm_sop_t wm_stencil_op;
	wire rsm_pscd_t wm_pscd;
	wire logic [31:0] sf_now = {4'h0, sf_scissor, sf_rta_idx, sf_vp_idx, 1'b0, sf_ms_mode, sf_wind, sf_cull, sf_fill,
		sf_hash_dis, sf_rtir, sf_vxf, sf_stat};
	wire logic [31:0] wm_now = {14'h0, wm_stat, wm_pscd, wm_kill, wm_dispatch, wm_stencil_op, wm_stencil_fn,
		wm_stencil_write, wm_stencil_test, wm_depth_write, wm_depth_fn, wm_depth_test};
	// every normal field but the ms mode (pixel, as forced for single-sample ops) differs from its forced value, so a missed override shows
	localparam logic [31:0] sf_nrm = {4'h0, 1'b1, 11'h5a5, 4'h9, 1'b0, 2'h2, 1'b1, 2'h2, 2'h1, 4'hf};
	// two windower patterns, since one cannot tell a forced bit from an equal normal one
	localparam logic [31:0] wa = {14'h0, 1'b1, 2'h1, 1'b1, 1'b1, 3'h3, 3'h2, 1'b1, 1'b1, 1'b0, 3'h4, 1'b1};
	localparam logic [31:0] wb = wa ^ 32'h0003_ffff;
	int miscompares = 0;
	int cmp_count = 0;
	logic [31:0] rd;
	logic er, to;
	logic [31:0] sf_want;
	logic [31:0] wm_want;
	rsm_row_t rows [13] = '{
		'{16'h0000, 3'h0, 16'hf0f3, 1'b0, 16'h0001}, '{16'h0000, 3'h1, 16'hf0f3, 1'b1, 16'h0003},
		'{16'h0000, 3'h2, 16'hf0f3, 1'b0, 16'h0003}, '{16'h0000, 3'h3, 16'hf0f3, 1'b1, 16'h00f3},
		'{16'h0000, 3'h4, 16'hf0f3, 1'b0, 16'hf0f3}, '{16'h0201, 3'h4, 16'hf0f3, 1'b1, 16'h000d},
		'{16'h0002, 3'h4, 16'hf0f3, 1'b0, 16'h0001}, '{16'h0104, 3'h4, 16'hf0f3, 1'b1, 16'h0001},
		'{16'h0308, 3'h4, 16'hf0f3, 1'b0, 16'h003d}, '{16'h1410, 3'h0, 16'hf0f3, 1'b1, 16'h3c3d},
		'{16'h0120, 3'h4, 16'hf0f3, 1'b0, 16'h0001}, '{16'h0011, 3'h4, 16'hf0f3, 1'b1, 16'h0001},
		'{16'h0003, 3'h4, 16'hf0f3, 1'b0, 16'h0001}};
	logic [31:0] rst_val [6] = '{`RSM_RST_OP, `RSM_RST_OP_MASK, `RSM_RST_SMASK, `RSM_RST_MSAA, `RSM_RST_SF,
		`RSM_RST_WM};
	rsm_top rsm_top_i(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.op_active_out, .sample_mask_out, .sf_stat, .sf_vxf, .sf_rtir, .sf_hash_dis, .sf_fill, .sf_cull, .sf_wind,
		.sf_ms_mode, .sf_rta_idx, .sf_vp_idx, .sf_scissor, .wm_depth_test, .wm_depth_fn, .wm_depth_write,
		.wm_stencil_test, .wm_stencil_write, .wm_stencil_fn, .wm_stencil_op, .wm_dispatch, .wm_kill, .wm_pscd, .wm_stat);
	rsm_apb_master rsm_apb_master_i(.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb);
	always #50 pclk = ~pclk;
	function automatic logic [31:0] sf_exp(logic [15:0] op);
		return (|op[5:0]) ? {4'h0, op[12], 16'h0, ((op[10:8] inside {[3'h1:3'h4]}) ? 2'h3 : 2'h2), 9'h0c0} : sf_nrm;
	endfunction
	function automatic logic [31:0] wm_exp(logic [15:0] op, logic [31:0] w);
		logic sc;
		logic dc;
		sc = op[4];
		dc = op[0];
		if (!(|op[5:0]))
			return w;
		return {19'h0, (sc ? 3'h2 : w[12:10]), (sc ? 3'h0 : w[9:7]), sc, sc, (sc ? dc : 1'b1), 3'h1,
			(op[1] | op[5]) & !dc & !sc};
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] want);
	begin
		cmp_count++;
		if (seen !== want)
		begin
			miscompares++;
			$display("Error at %0t: got %h, expected %h", $time, seen, want);
		end
	end
	endtask
	task bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
	begin
		rsm_apb_master_i.xfer(wr, a, d, s, rd, er, to);
		if (to)
		begin
			miscompares++;
			$display("Error at %0t: no answer on the bus", $time);
			conclude;
		end
	end
	endtask
	task conclude;
	begin
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		bus(1'b1, `RSM_OFF_OP_MASK, 32'h0000_3c3d, 4'hf);
		bus(1'b1, `RSM_OFF_SF_NORM, sf_nrm, 4'hf);
		for (int i = 0; i < 13; i++)
		begin
			bus(1'b1, `RSM_OFF_OP, {16'h0, rows[i].op}, 4'hf);
			bus(1'b1, `RSM_OFF_MSAA, {29'h0, rows[i].cnt}, 4'hf);
			bus(1'b1, `RSM_OFF_SMASK, {16'h0, rows[i].smask}, 4'hf);
			bus(1'b1, `RSM_OFF_WM_NORM, rows[i].alt ? wb : wa, 4'hf);
			@(posedge pclk);
			@(negedge pclk);
			chk({16'h0, sample_mask_out}, {16'h0, rows[i].mask});
			chk({31'h0, op_active_out}, {31'h0, |rows[i].op[5:0]});
			sf_want = sf_exp(rows[i].op);
			wm_want = wm_exp(rows[i].op, rows[i].alt ? wb : wa);
			chk(sf_now & 32'h0000_07c0, sf_want & 32'h0000_07c0);
			chk(sf_now & 32'hffff_f83f, sf_want & 32'hffff_f83f);
			chk(wm_now & 32'h0000_001f, wm_want & 32'h0000_001f);
			chk(wm_now & 32'h0000_1fe0, wm_want & 32'h0000_1fe0);
			chk(wm_now & 32'hffff_e000, wm_want & 32'hffff_e000);
			$display("test %0d done", i);
		end
		bus(1'b1, `RSM_OFF_OP, 32'hffff_ffff, 4'hf);
		bus(1'b0, `RSM_OFF_OP, 32'h0000_0000, 4'h0);
		chk(rd, `RSM_WMASK_OP);
		chk({31'h0, er}, 32'h0000_0000);
		chk(wm_now, wm_exp(16'h173f, wa));
		chk(sf_now, sf_exp(16'h173f));
		bus(1'b1, `RSM_OFF_OP, 32'h0000_0000, 4'h2);
		bus(1'b0, `RSM_OFF_STATUS, 32'h0000_0000, 4'h0);
		chk(rd, 32'h0001_0001);
		bus(1'b1, `RSM_OFF_STATUS, 32'h0000_0000, 4'hf);
		chk({31'h0, er}, 32'h0000_0001);
		bus(1'b0, 12'h024, 32'h0000_0000, 4'h0);
		chk({31'h0, er}, 32'h0000_0001);
		chk(rd, 32'h0000_0000);
		$display("test register access done");
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		chk({15'h0, op_active_out, sample_mask_out} | sf_now | wm_now, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 6; k++)
		begin
			bus(1'b0, 12'(4 * k), 32'h0000_0000, 4'h0);
			chk(rd, rst_val[k]);
		end
		chk({16'h0, sample_mask_out}, 32'h0000_0001);
		$display("test reset done");
		conclude;
	end
endmodule
